// >>> host_link_model.sv
// Purpose: host sector source and verify engine stand-in
// Assumes: bench gives the sector count at each taken command
// Notes:   stalls at random; verify takes 10 to 15 cycles
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
  // Job from the bench
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        cmd_take,
  input wire logic [15:0] nsec,
  input wire logic        final_cmd,
  // Device side
  input wire logic        sect_ready,
  output var logic        sect_valid,
  output var logic        last_segment,
  input wire logic        verify_start_q,
  output var logic        verify_done
);
  logic [15:0] left_q = 16'h0;
  int          wait_q = 0;
  logic        acc;
  initial {sect_valid, last_segment, verify_done} = 3'b000;
  always @(posedge clk_sys) begin
    acc = sect_valid && sect_ready;
    left_q = srst ? 16'h0 : cmd_take ? nsec : left_q - 16'(acc);
    wait_q = srst ? 0 : verify_start_q ? 10 + $urandom % 6 :
             wait_q - int'(wait_q > 0);
    #2;
    // A raised valid holds until a whole sector is taken
    if (!sect_valid || acc || left_q == 16'h0)
      sect_valid = left_q != 16'h0 && $urandom % 4 != 0;
    last_segment = final_cmd && left_q == 16'h1;
    verify_done = wait_q == 1;
  end
endmodule // host_link_model
`default_nettype wire

// >>> microcode_download_command.v
// Purpose: interpreter of the microcode download command on the device
// Assumes: host keeps its side of the protocol; inputs synchronous
// Notes:   image content is opaque; verify and reload are external
//
// How it works
// - Opcode 92h selects this command; others are ignored.
// - Only subcommands 03h, 07h, 0Eh, 0Fh are accepted; others abort.
// - Security locked state aborts the command whatever the subcommand.
// - Abort sets error bit 2 and status error bit.
// - Block count is sector number byte high, count byte low.
// - Zero block count transfers no data.
// - Offset comes from LBA 23:8, used only with 03h and 0Eh.
// - Offset is counted in 512-byte units of the image.
// - Out-of-sequence offset aborts and discards received segments.
// - Final segment is verified and saved; immediate modes activate then.
// - Subcommand 0Eh stores the image pending, not active.
// - Pending image is activated only by subcommand 0Fh.
// - Reset discards partial downloads and pending images.
// - Reload with spin-up disabled requests a spin-down.
// - Failed requested reload sets uncorrectable flag; otherwise never.
// - Error completion shows CRC bit 7, status bits 5, 1, 0.
`timescale 1ns/1ns
`default_nettype none
`include "ucode_dl_defs.vh"
module microcode_download_command (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        srst,
  // Command block from the host
  input  wire        cmd_valid,
  input  wire [7:0]  cmd_opcode,
  input  wire [7:0]  cmd_feature,
  input  wire [7:0]  cmd_count,
  input  wire [27:0] cmd_lba,
  output wire        cmd_ready,
  // Device state
  input  wire        security_locked,
  input  wire        spinup_disabled,
  input  wire        iface_crc_err,
  input  wire        dev_fault,
  input  wire        sense_avail,
  // Sector data stream
  input  wire        sect_valid,
  output wire        sect_ready,
  input  wire        last_segment,
  input  wire        reload_requested,
  // Verify and save engine
  output reg         verify_start_q,
  input  wire        verify_done,
  input  wire        verify_ok,
  input  wire        reload_ok,
  // Image state and actions
  output reg         image_pending_q,
  output reg         image_activate_q,
  output reg         discard_q,
  output reg         spin_down_q,
  output reg  [15:0] xfer_offset_q,
  // Completion
  output reg         done_q,
  output reg  [7:0]  error_reg_q,
  output reg  [7:0]  status_reg_q,
  output reg  [15:0] exp_offset_q
);

  // ************************************************************
  // States
  // ************************************************************
  localparam [2:0] ST_IDLE   = 3'd0;
  localparam [2:0] ST_DATA   = 3'd1;
  localparam [2:0] ST_VERIFY = 3'd2;
  localparam [2:0] ST_WAIT   = 3'd3;
  localparam [2:0] ST_DONE   = 3'd4;
  // Minimum verify latency, held as an integer so no bits are cut
  localparam integer VWAIT_LIMIT = `VERIFY_CYCLES;

  reg [2:0]  state_q;
  reg [15:0] remain_q;
  reg        defer_q;
  reg        last_q;
  reg        reload_q;
  reg        is_ofs_q;
  reg [7:0]  vwait_q;

  wire       sub_valid;
  wire       sub_uses_ofs;
  wire       sub_defer;
  wire       sub_activate;
  wire [15:0] blk_count;
  wire [15:0] seg_offset;
  wire       ofs_bad;
  wire       take;

  ucode_subcmd_check u_sub (
    .subcmd       (cmd_feature),
    .sub_valid    (sub_valid),
    .sub_uses_ofs (sub_uses_ofs),
    .sub_defer    (sub_defer),
    .sub_activate (sub_activate)
  );

  assign blk_count  = {cmd_lba[7:0], cmd_count};
  // Offset in 512-byte sectors, so it adds directly to block counts
  assign seg_offset = sub_uses_ofs ? cmd_lba[23:8] : 16'h0000;
  assign ofs_bad    = sub_uses_ofs && (seg_offset != exp_offset_q);
  assign cmd_ready  = (state_q == ST_IDLE);
  // Partial sectors cannot arise: the stream moves whole sectors only
  assign sect_ready = (state_q == ST_DATA);
  assign take       = cmd_valid && cmd_ready &&
                      (cmd_opcode == `OPC_UCODE_DL);

  // ************************************************************
  // Command sequencer
  // ************************************************************
  always @(posedge clk_sys) begin
    if (srst) begin
      state_q          <= ST_IDLE;
      remain_q         <= 16'h0000;
      defer_q          <= 1'b0;
      last_q           <= 1'b0;
      reload_q         <= 1'b0;
      is_ofs_q         <= 1'b0;
      vwait_q          <= 8'h00;
      verify_start_q   <= 1'b0;
      image_pending_q  <= 1'b0;
      image_activate_q <= 1'b0;
      discard_q        <= 1'b1;
      spin_down_q      <= 1'b0;
      xfer_offset_q    <= 16'h0000;
      done_q           <= 1'b0;
      error_reg_q      <= 8'h00;
      status_reg_q     <= 8'h00;
      exp_offset_q     <= 16'h0000;
    end else begin
      verify_start_q   <= 1'b0;
      image_activate_q <= 1'b0;
      discard_q        <= 1'b0;
      spin_down_q      <= 1'b0;
      done_q           <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            error_reg_q  <= 8'h00;
            status_reg_q <= 8'h00;
            if (security_locked || !sub_valid || ofs_bad) begin
              error_reg_q[`ERR_ABORT_BIT] <= 1'b1;
              error_reg_q[`ERR_CRC_BIT]   <= iface_crc_err;
              status_reg_q[`STS_ERR_BIT]  <= 1'b1;
              status_reg_q[`STS_FAULT_BIT] <= dev_fault;
              status_reg_q[`STS_SENSE_BIT] <= sense_avail;
              if (ofs_bad) begin
                discard_q <= 1'b1;
              end
              exp_offset_q <= 16'h0000;
              state_q      <= ST_DONE;
            end else if (sub_activate) begin
              if (image_pending_q) begin
                image_activate_q <= 1'b1;
                image_pending_q  <= 1'b0;
                spin_down_q      <= spinup_disabled;
              end
              state_q <= ST_DONE;
            end else begin
              defer_q       <= sub_defer;
              is_ofs_q      <= sub_uses_ofs;
              remain_q      <= blk_count;
              xfer_offset_q <= seg_offset;
              last_q        <= 1'b0;
              reload_q      <= 1'b0;
              if (sub_uses_ofs) begin
                exp_offset_q <= exp_offset_q + blk_count;
              end
              state_q <= (blk_count == 16'h0000) ? ST_DONE : ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (sect_valid) begin
            remain_q      <= remain_q - 16'h0001;
            xfer_offset_q <= xfer_offset_q + 16'h0001;
            if (last_segment) begin
              last_q <= 1'b1;
            end
            if (reload_requested) begin
              reload_q <= 1'b1;
            end
            if (remain_q == 16'h0001) begin
              // Full-image mode ends every command as a complete image
              if (last_segment || last_q || !is_ofs_q) begin
                state_q <= ST_VERIFY;
              end else begin
                state_q <= ST_DONE;
              end
            end
          end
        end
        ST_VERIFY: begin
          verify_start_q <= 1'b1;
          vwait_q        <= 8'h00;
          state_q        <= ST_WAIT;
        end
        ST_WAIT: begin
          // Hold off sampling for the minimum verify latency
          if ({24'h000000, vwait_q} < VWAIT_LIMIT) begin
            vwait_q <= vwait_q + 8'h01;
          end else if (verify_done) begin
            exp_offset_q <= 16'h0000;
            if (!verify_ok) begin
              discard_q                    <= 1'b1;
              error_reg_q[`ERR_ABORT_BIT]  <= 1'b1;
              error_reg_q[`ERR_CRC_BIT]    <= iface_crc_err;
              status_reg_q[`STS_ERR_BIT]   <= 1'b1;
              status_reg_q[`STS_FAULT_BIT] <= dev_fault;
              status_reg_q[`STS_SENSE_BIT] <= sense_avail;
            end else if (defer_q) begin
              image_pending_q <= 1'b1;
            end else begin
              image_pending_q  <= 1'b0;
              image_activate_q <= 1'b1;
              spin_down_q      <= spinup_disabled;
              if (reload_q && !reload_ok) begin
                error_reg_q[`ERR_UNC_BIT]    <= 1'b1;
                error_reg_q[`ERR_CRC_BIT]    <= iface_crc_err;
                status_reg_q[`STS_ERR_BIT]   <= 1'b1;
                status_reg_q[`STS_FAULT_BIT] <= dev_fault;
                status_reg_q[`STS_SENSE_BIT] <= sense_avail;
              end
            end
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          done_q  <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // microcode_download_command
`default_nettype wire

// >>> testbench.sv
// Purpose: self-checking bench for the download interpreter
// Assumes: host model feeds sectors and answers verify
// Notes:   random subcommands and counts from a fixed seed
`timescale 1ns/1ns
`default_nettype none
`include "ucode_dl_defs.vh"
module testbench;
  logic clk_sys = 0, srst = 1, cmd_valid = 0, security_locked = 0;
  logic spinup_disabled = 0, iface_crc_err = 0, dev_fault = 0;
  logic sense_avail = 0, final_cmd = 0, reload_requested = 0;
  logic reload_ok = 1, act_q, spin_q;
  logic [7:0] cmd_opcode = 0, cmd_feature = 0, cmd_count = 0;
  logic [27:0] cmd_lba = 0;
  logic [15:0] nsec = 0, eo = 0;
  logic [7:0] subs [4] = '{8'h03, 8'h07, 8'h0E, 8'h0F};
  wire cmd_ready, sect_valid, sect_ready, last_segment, verify_start_q;
  wire verify_done, image_pending_q, image_activate_q, discard_q;
  wire spin_down_q, done_q;
  wire [7:0] error_reg_q, status_reg_q;
  wire [15:0] xfer_offset_q, exp_offset_q;
  wire cmd_take = cmd_valid && cmd_ready && cmd_opcode == `OPC_UCODE_DL;
  int errors = 0, checks = 0, cyc = 0, i, k;
  microcode_download_command dut (
    .clk_sys, .srst, .cmd_valid, .cmd_opcode, .cmd_feature, .cmd_count,
    .cmd_lba, .cmd_ready, .security_locked, .spinup_disabled,
    .iface_crc_err, .dev_fault, .sense_avail, .sect_valid, .sect_ready,
    .last_segment, .reload_requested, .verify_start_q, .verify_done,
    .verify_ok(1'b1), .reload_ok, .image_pending_q, .image_activate_q,
    .discard_q, .spin_down_q, .xfer_offset_q, .done_q, .error_reg_q,
    .status_reg_q, .exp_offset_q);
  host_link_model partner (
    .clk_sys, .srst, .cmd_take, .nsec, .final_cmd, .sect_ready,
    .sect_valid, .last_segment, .verify_start_q, .verify_done);
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (image_activate_q) act_q <= 1'b1;
    if (spin_down_q) spin_q <= 1'b1;
    if (cyc == 40000) begin
      errors++;
      conclude();
    end
  end
  task chk(input string nm, input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task conclude();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One command; expectations follow from subcommand, lock and offset
  task run(input logic [7:0] f, input logic [15:0] cnt, ofs,
           input logic fin);
    logic bad, fail;
    bad = security_locked || !(f inside {8'h03, 8'h07, 8'h0E, 8'h0F}) ||
          ((f == 8'h03 || f == 8'h0E) && ofs != eo);
    fin = (fin || f == 8'h07) && cnt != 16'h0000;
    fail = !bad && fin && f != 8'h0F && reload_requested && !reload_ok;
    {cmd_valid, cmd_opcode, cmd_feature} = {1'b1, `OPC_UCODE_DL, f};
    {cmd_lba, cmd_count} = {4'h0, ofs, cnt};
    nsec = (bad || f == 8'h0F) ? 16'h0 : cnt;
    final_cmd = fin;
    {act_q, spin_q} = 2'b00;
    do @(posedge clk_sys); while (!cmd_ready);
    #2 cmd_valid = 0;
    for (i = 0; i < 5000 && !done_q; i++) begin
      @(posedge clk_sys);
      #2;
    end
    chk("done", i < 5000, 1);
    chk("abort", error_reg_q[`ERR_ABORT_BIT], bad);
    chk("errbit", status_reg_q[`STS_ERR_BIT], bad || fail);
    chk("unc", error_reg_q[`ERR_UNC_BIT], fail);
    if (!bad && f != 8'h0F && cnt != 16'h0000)
      chk("xfer", xfer_offset_q, (f == 8'h07) ? cnt : ofs + cnt);
    if (!bad && f != 8'h0F) eo = fin ? 16'h0 : eo + cnt;
    if (bad) eo = 16'h0;
    chk("nextofs", exp_offset_q, eo);
    if (!bad && !fail && fin && f != 8'h0E && f != 8'h0F)
      chk("live", act_q, 1);
  endtask
  initial begin
    k = $urandom(32'h8E1C);
    repeat (10) @(posedge clk_sys);
    #2 chk("discard", discard_q, 1);
    srst = 0;
    {cmd_valid, cmd_opcode} = {1'b1, 8'hEC};
    repeat (3) @(posedge clk_sys);
    #2 chk("ignored", {done_q, cmd_ready}, 2'b01);
    run(8'h00, 1, 0, 0);
    run(8'hFF, 1, 0, 0);
    for (k = 0; k < 8; k++) run(8'($urandom), 16'($urandom % 4), 0, 0);
    {security_locked, iface_crc_err, dev_fault, sense_avail} = 4'hF;
    for (k = 0; k < 4; k++) run(subs[k], 1, 0, 1);
    chk("flags", {error_reg_q[7], status_reg_q[5], status_reg_q[1]}, 7);
    {security_locked, iface_crc_err, dev_fault, sense_avail} = 4'h0;
    run(8'h03, 16'h0102, 0, 0);
    run(8'h03, 2, 16'h0102, 0);
    run(8'h03, 1, 5, 0);
    run(8'h03, 0, 0, 0);
    {reload_requested, reload_ok} = 2'b10;
    run(8'h03, 1, 0, 1);
    {reload_requested, reload_ok, spinup_disabled} = 3'b111;
    run(8'h07, 2, 0, 1);
    chk("spin", spin_q, 1);
    {reload_requested, spinup_disabled} = 2'b00;
    run(8'h0E, 3, 0, 1);
    chk("pend", {image_pending_q, act_q}, 2'b10);
    run(8'h0F, 0, 0, 0);
    chk("activate", {image_pending_q, act_q}, 2'b01);
    run(8'h0E, 1, 0, 1);
    run(8'h03, 1, 0, 0);
    srst = 1;
    @(posedge clk_sys);
    #2 chk("drop", {discard_q, image_pending_q}, 2'b10);
    {srst, eo} = 17'h0;
    run(8'h03, 1, 1, 0);
    conclude();
  end
endmodule // testbench
`default_nettype wire

// >>> ucode_dl_assertions.sv
// Purpose: port assertions for the download interpreter
// Assumes: one clock domain, synchronous reset
// Notes:   bound to every instance of the interpreter
`timescale 1ns/1ns
`default_nettype none
`include "ucode_dl_defs.vh"
module ucode_dl_chk (
  // Watched ports
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_opcode,
  input wire logic [7:0]  cmd_feature,
  input wire logic [7:0]  cmd_count,
  input wire logic [27:0] cmd_lba,
  input wire logic        cmd_ready,
  input wire logic        security_locked,
  input wire logic        spinup_disabled,
  input wire logic        sect_valid,
  input wire logic        sect_ready,
  input wire logic        last_segment,
  input wire logic        verify_start_q,
  input wire logic        spin_down_q,
  input wire logic        done_q,
  input wire logic [7:0]  error_reg_q,
  input wire logic [7:0]  status_reg_q,
  input wire logic [15:0] exp_offset_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_take;
    cmd_valid && cmd_ready && cmd_opcode == `OPC_UCODE_DL;
  endsequence
  sequence s_abort;
    ##2 done_q && error_reg_q[`ERR_ABORT_BIT];
  endsequence
  a_locked_abort: assert property (
    s_take ##0 security_locked |-> s_abort) else $error("lock not aborted");
  a_bad_sub: assert property (
    s_take ##0 !(cmd_feature inside {8'h03, 8'h07, 8'h0E, 8'h0F})
    |-> s_abort) else $error("bad subcommand not aborted");
  a_zero_count: assert property (
    s_take ##0 {cmd_lba[7:0], cmd_count} == 16'h0
    |=> !sect_ready ##1 done_q) else $error("zero count moved data");
  a_other_opcode: assert property (
    cmd_valid && cmd_ready && cmd_opcode != `OPC_UCODE_DL |=> cmd_ready)
    else $error("foreign opcode taken");
  a_final_verify: assert property (
    sect_valid && sect_ready && last_segment |-> ##2 verify_start_q)
    else $error("final segment not verified");
  a_abort_status: assert property (
    done_q && error_reg_q[`ERR_ABORT_BIT] |-> status_reg_q[`STS_ERR_BIT])
    else $error("abort without status error");
  a_spin_cause: assert property (
    $rose(spin_down_q) |-> $past(spinup_disabled))
    else $error("stray spin-down");
  a_offset_clear: assert property (
    done_q && error_reg_q[`ERR_ABORT_BIT] |-> ##[0:1] exp_offset_q == 16'h0)
    else $error("offset kept after abort");
endmodule // ucode_dl_chk
bind microcode_download_command ucode_dl_chk u_chk (
  .clk_sys, .srst, .cmd_valid, .cmd_opcode, .cmd_feature, .cmd_count,
  .cmd_lba, .cmd_ready, .security_locked, .spinup_disabled, .sect_valid,
  .sect_ready, .last_segment, .verify_start_q, .spin_down_q, .done_q,
  .error_reg_q, .status_reg_q, .exp_offset_q);
`default_nettype wire

// >>> ucode_dl_defs.vh
// Purpose: constants for the microcode download command interpreter
// Assumes: included by bare name
// Notes:   definitions only
`ifndef UCODE_DL_DEFS_VH
`define UCODE_DL_DEFS_VH

`define OPC_UCODE_DL      8'h92
`define SUB_OFS_SAVE      8'h03
`define SUB_FULL_SAVE     8'h07
`define SUB_OFS_DEFER     8'h0E
`define SUB_ACTIVATE      8'h0F
`define ERR_CRC_BIT       7
`define ERR_UNC_BIT       6
`define ERR_ABORT_BIT     2
`define STS_FAULT_BIT     5
`define STS_SENSE_BIT     1
`define STS_ERR_BIT       0
`define SECTOR_BYTES      512
`define VERIFY_TIME_NS    200
`define CLK_PERIOD_NS     20
`define VERIFY_CYCLES     ((`VERIFY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> ucode_subcmd_check.v
// Purpose: classify the subcommand byte of the download command
// Assumes: combinational, one cycle of decode
// Notes:   offset use is limited to the two offset-method subcommands
`timescale 1ns/1ns
`default_nettype none
`include "ucode_dl_defs.vh"
module ucode_subcmd_check (
  // Subcommand in
  input  wire [7:0] subcmd,
  // Decode out
  output wire       sub_valid,
  output wire       sub_uses_ofs,
  output wire       sub_defer,
  output wire       sub_activate
);
  assign sub_valid    = (subcmd == `SUB_OFS_SAVE) ||
                        (subcmd == `SUB_FULL_SAVE) ||
                        (subcmd == `SUB_OFS_DEFER) ||
                        (subcmd == `SUB_ACTIVATE);
  assign sub_uses_ofs = (subcmd == `SUB_OFS_SAVE) ||
                        (subcmd == `SUB_OFS_DEFER);
  assign sub_defer    = (subcmd == `SUB_OFS_DEFER);
  assign sub_activate = (subcmd == `SUB_ACTIVATE);
endmodule // ucode_subcmd_check
`default_nettype wire
